// [src/dcd_pkg.sv]
// dcd_pkg: constants, types and helpers of the disk channel datapath.
// assumes one 20 MHz clock and a plain register port beside the link.
// Behaviour
// - host word in six 12-bit, forwarded five 16-bit
// - word is 64 data plus 8 check bits
// - read word returned as six 12-bit beats
// - write checker regenerates checks, classifies faults
// - single error: flip bit, report single error
// - double error: no correction, report double error
// - odd parity per byte of each parcel
// - two ECC units, four bit-pair circuits each
// - ECC per sector, emitted after sector as bytes
// - units forward ECC bytes to transmit link
// - read ECC compared with stored ECC bytes
// - three command registers strobed onto bus A
// - parcel low byte bus B, high byte A
// - status byte from bus B to status register
// - failing head rebuilt from others and parity
// - read checker builds checks over four parcels
// - read byte parity errors reported per bus
// - ID parameters compared against read ID field
// - parcel counter and defect pad counter
// - transfer counter loads, decrements, flags zero
// - sequencer address increments, clears or branches
// - 1024 by 32 sequencer memory, host access
// - nine lines per bus, odd parity
package dcd_pkg;
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_CMD_I = 8'h04;
    localparam logic [7:0] REG_CMD_J = 8'h08;
    localparam logic [7:0] REG_CMD_K = 8'h0C;
    localparam logic [7:0] REG_ID1 = 8'h10;
    localparam logic [7:0] REG_ID0 = 8'h14;
    localparam logic [7:0] REG_XFER = 8'h18;
    localparam logic [7:0] REG_DEFECT = 8'h1C;
    localparam logic [7:0] REG_STATUS = 8'h20;
    localparam logic [7:0] REG_PARCEL = 8'h24;
    localparam logic [7:0] REG_SEQ_PTR = 8'h28;
    localparam logic [7:0] REG_SEQ_DATA = 8'h2C;
    localparam logic [7:0] REG_SEQ_ADDR = 8'h30;
    localparam logic [2:0] HOST_LAST = 3'h5;
    localparam logic [2:0] FWD_LAST = 3'h4;
    localparam logic [2:0] SEND_LAST = 3'h3;
    localparam logic [1:0] RD_LAST = 2'h3;
    localparam logic [15:0] SECTOR_LAST = 16'h00FF;
    localparam logic [15:0] SEC_END = 16'h0103;
    localparam logic [7:0] ECC_POLY = 8'h1D;
    localparam int SEQ_DEPTH = 1024;
    localparam int SQ_CLR = 31;
    localparam int SQ_BR = 30;
    localparam int SQ_COND = 27;
    localparam int SQ_TGT = 16;
    localparam int SQ_SEL_SET = 15;
    localparam int SQ_SEL_CLR = 14;
    localparam int SQ_MST_SET = 13;
    localparam int SQ_MST_CLR = 12;
    localparam int SQ_CMD = 10;
    localparam int SQ_HALT = 9;

    typedef struct packed {
        logic [7:0] d;
        logic p;
    } dcd_byte_type;

    typedef struct packed {
        logic id_miss;
        logic ecc;
        logic par1;
        logic par0;
        logic dbe;
        logic sbe;
    } dcd_err_type;

    typedef enum logic [2:0] {
        MODE_IDLE = 3'b000,
        MODE_WRITE = 3'b001,
        MODE_READ = 3'b010,
        MODE_ID = 3'b011,
        MODE_STAT = 3'b100
    } dcd_mode_type;

    typedef enum logic [1:0] {
        W_COLLECT = 2'b00,
        W_FWD = 2'b01,
        W_CHECK = 2'b10,
        W_SEND = 2'b11
    } dcd_wst_type;

    function automatic logic dcd_odd(input logic [7:0] b);
        return ~^b;
    endfunction : dcd_odd

    // hamming positions 1..71, data skips powers of two; bit 7 is overall parity
    function automatic logic [7:0] dcd_chk(input logic [63:0] d);
        logic [7:0] c;
        int k;
        c = '0;
        k = 0;
        for (int p = 1; p < 72; p++)
            if ((p & (p - 1)) != 0)
            begin
                for (int b = 0; b < 7; b++)
                    if (p[b])
                        c[b] = c[b] ^ d[k];
                c[7] = c[7] ^ d[k];
                k++;
            end
        c[7] = c[7] ^ (^c[6:0]);
        return c;
    endfunction : dcd_chk

    function automatic logic [63:0] dcd_fix(input logic [6:0] s);
        logic [63:0] m;
        int k;
        m = '0;
        k = 0;
        for (int p = 1; p < 72; p++)
            if ((p & (p - 1)) != 0)
            begin
                if (p[6:0] == s)
                    m[k] = 1'b1;
                k++;
            end
        return m;
    endfunction : dcd_fix

    function automatic logic [7:0] dcd_ecc_step(input logic [7:0] e, input logic [1:0] b);
        logic [7:0] r;
        r = e;
        for (int i = 0; i < 2; i++)
            r = {r[6:0], 1'b0} ^ ({8{r[7] ^ b[i]}} & ECC_POLY);
        return r;
    endfunction : dcd_ecc_step
endpackage : dcd_pkg

// [src/dcd_datapath.sv]
// dcd_datapath: host word path, SECDED, sector ECC, drive link and sequencer.
// assumes mclk at 20 MHz, drive pins asynchronous, host port on mclk.
`timescale 1ns/1ps
module dcd_datapath (
    // clock, reset, enable
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic ce,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // host word port
    input wire logic [11:0] host_wr_data,
    input wire logic host_wr_valid,
    output logic host_wr_ready,
    output logic [11:0] host_rd_data,
    output logic host_rd_valid,
    input wire logic host_rd_ready,
    // drive link
    input wire dcd_pkg::dcd_byte_type bus_a_in,
    input wire dcd_pkg::dcd_byte_type bus_b_in,
    output dcd_pkg::dcd_byte_type bus_a_out,
    output dcd_pkg::dcd_byte_type bus_b_out,
    output logic bus_a_oe_b,
    output logic bus_b_oe_b,
    input wire logic slave_in,
    input wire logic sync_in,
    output logic select_out,
    output logic master_out,
    output logic sync_out
);
    import dcd_pkg::*;

    dcd_byte_type a_m_r, a_s_r, b_m_r, b_s_r;
    logic [1:0] pin_m_r, pin_s_r;
    dcd_mode_type mode_r;
    logic run_r, bsr_en_r;
    logic [2:0] bsr_head_r;
    logic [2:0][7:0] cmd_r;
    logic [15:0] id1_r, id0_r, xfer_r, defect_r, parcel_r, sec_r, rxp;
    dcd_err_type stat_r, err_set;
    logic [7:0] stat_byte_r, syn, cmd_sel, cond;
    logic stat_seen_r, id_hit0_r, id_match_r;
    logic [9:0] seq_ptr_r, seq_addr_r;
    logic [31:0] seq_mem [SEQ_DEPTH];
    logic [31:0] sq_w;
    dcd_wst_type wst_r;
    logic [2:0] wcnt_r, hcnt_r;
    logic [1:0] rcnt_r;
    logic [71:0] hw_r, rw_r;
    logic [79:0] cw_r;
    logic [3:0][7:0] elo_r, ehi_r;
    logic [15:0] tx_par, ecc_in;
    logic wr_ctrl, stat_rd, wr_sdata, ovr, sgl, dbl, ecc_ph, pad;
    logic tx_take, tx_data, rx_take, rd_data, sec_adv, cmd_stb, par_bad0, par_bad1;

    // the drive pins are asynchronous to mclk
    always_ff @(posedge mclk)
        if (!rst_b)
        begin
            a_m_r <= '0;
            a_s_r <= '0;
            b_m_r <= '0;
            b_s_r <= '0;
            pin_m_r <= '0;
            pin_s_r <= '0;
        end
        else if (ce)
        begin
            a_m_r <= bus_a_in;
            a_s_r <= a_m_r;
            b_m_r <= bus_b_in;
            b_s_r <= b_m_r;
            pin_m_r <= {slave_in, sync_in};
            pin_s_r <= pin_m_r;
        end

    assign wr_ctrl = ce && reg_wr && reg_addr == REG_CTRL;
    assign wr_sdata = ce && reg_wr && reg_addr == REG_SEQ_DATA;
    assign stat_rd = ce && reg_rd && reg_addr == REG_STATUS;

    // write path: host beats, checker forward, SECDED, send
    assign host_wr_ready = wst_r == W_COLLECT;
    assign syn = dcd_chk(cw_r[63:0]) ^ cw_r[71:64];
    assign ovr = ^cw_r[71:0];
    assign sgl = ovr;
    assign dbl = !ovr && syn[6:0] != '0;
    assign ecc_ph = sec_r > SECTOR_LAST;
    assign pad = defect_r != '0;
    assign tx_take = ce && mode_r == MODE_WRITE && pin_s_r[0] && !sync_out && (pad || ecc_ph || wst_r == W_SEND);
    assign tx_data = tx_take && !pad && !ecc_ph;
    assign rx_take = ce && pin_s_r[0] && !sync_out && !host_rd_valid
        && (mode_r == MODE_READ || mode_r == MODE_ID || mode_r == MODE_STAT);
    assign rd_data = rx_take && mode_r == MODE_READ && !ecc_ph;
    assign sec_adv = (tx_take && !pad) || (rx_take && mode_r != MODE_STAT);

    always_ff @(posedge mclk)
        if (!rst_b)
        begin
            wst_r <= W_COLLECT;
            wcnt_r <= '0;
            hw_r <= '0;
            cw_r <= '0;
        end
        else if (ce)
            unique case (wst_r)
                W_COLLECT:
                    if (host_wr_valid)
                    begin
                        hw_r <= {host_wr_data, hw_r[71:12]};
                        wcnt_r <= (wcnt_r == HOST_LAST) ? 3'h0 : wcnt_r + 3'h1;
                        if (wcnt_r == HOST_LAST)
                            wst_r <= W_FWD;
                    end
                W_FWD:
                begin
                    cw_r <= {hw_r[15:0], cw_r[79:16]};
                    hw_r <= {16'h0000, hw_r[71:16]};
                    wcnt_r <= (wcnt_r == FWD_LAST) ? 3'h0 : wcnt_r + 3'h1;
                    if (wcnt_r == FWD_LAST)
                        wst_r <= W_CHECK;
                end
                W_CHECK:
                begin
                    if (sgl)
                    begin
                        cw_r[63:0] <= cw_r[63:0] ^ dcd_fix(syn[6:0]);
                        // a flipped check bit is repaired as well, so the held word stays consistent
                        cw_r[71:64] <= dcd_chk(cw_r[63:0] ^ dcd_fix(syn[6:0]));
                    end
                    wst_r <= W_SEND;
                end
                W_SEND:
                    if (tx_data)
                    begin
                        cw_r <= {16'h0000, cw_r[79:16]};
                        wcnt_r <= (wcnt_r == SEND_LAST) ? 3'h0 : wcnt_r + 3'h1;
                        if (wcnt_r == SEND_LAST)
                            wst_r <= W_COLLECT;
                    end
            endcase

    // ECC byte index follows sec_r because the sector ends on a 4-aligned count
    always_comb
        if (pad)
            tx_par = '0;
        else if (ecc_ph)
            tx_par = {ehi_r[sec_r[1:0]], elo_r[sec_r[1:0]]};
        else
            tx_par = cw_r[15:0];

    assign ecc_in = (mode_r == MODE_WRITE) ? tx_par : rxp;

    always_ff @(posedge mclk)
        if (!rst_b)
        begin
            elo_r <= '0;
            ehi_r <= '0;
        end
        else if (ce)
        begin
            if (wr_ctrl || (sec_adv && sec_r == SEC_END))
            begin
                elo_r <= '0;
                ehi_r <= '0;
            end
            else if (tx_data || rd_data)
                for (int c = 0; c < 4; c++)
                begin
                    elo_r[c] <= dcd_ecc_step(elo_r[c], {ecc_in[c + 8], ecc_in[c]});
                    ehi_r[c] <= dcd_ecc_step(ehi_r[c], {ecc_in[c + 12], ecc_in[c + 4]});
                end
        end

    always_ff @(posedge mclk)
        if (!rst_b)
        begin
            sec_r <= '0;
            parcel_r <= '0;
            defect_r <= '0;
        end
        else if (ce)
        begin
            if (wr_ctrl)
                sec_r <= '0;
            else if (sec_adv)
                sec_r <= (sec_r == SEC_END && mode_r != MODE_ID) ? 16'h0000 : sec_r + 16'h0001;
            if (tx_take || rx_take)
                parcel_r <= parcel_r + 16'h0001;
            if (reg_wr && reg_addr == REG_DEFECT)
                defect_r <= reg_wdata[15:0];
            else if (tx_take && pad)
                defect_r <= defect_r - 16'h0001;
        end

    // transmit link
    assign cmd_stb = ce && run_r && sq_w[SQ_CMD +: 2] != 2'h0;
    assign cmd_sel = cmd_r[sq_w[SQ_CMD +: 2] - 2'h1];

    always_ff @(posedge mclk)
        if (!rst_b)
        begin
            // a zero byte still carries odd parity once the bus is enabled
            bus_a_out <= 9'h001;
            bus_b_out <= 9'h001;
            bus_a_oe_b <= 1'b1;
            bus_b_oe_b <= 1'b1;
            sync_out <= 1'b0;
        end
        else if (ce)
        begin
            sync_out <= tx_take || rx_take;
            bus_b_oe_b <= mode_r != MODE_WRITE;
            bus_a_oe_b <= !(mode_r == MODE_WRITE || cmd_stb);
            if (cmd_stb)
                bus_a_out <= {cmd_sel, dcd_odd(cmd_sel)};
            else if (tx_take)
                bus_a_out <= {tx_par[15:8], dcd_odd(tx_par[15:8])};
            if (tx_take)
                bus_b_out <= {tx_par[7:0], dcd_odd(tx_par[7:0])};
        end

    // receive link; parity is judged after rebuild so a known bad head does not flood errors
    always_comb
    begin
        rxp = {a_s_r.d, b_s_r.d};
        if (bsr_en_r)
        begin
            rxp[bsr_head_r] = ~^{b_s_r.d & ~(8'h01 << bsr_head_r), b_s_r.p};
            rxp[bsr_head_r + 4'h8] = ~^{a_s_r.d & ~(8'h01 << bsr_head_r), a_s_r.p};
        end
    end

    assign par_bad0 = b_s_r.p != dcd_odd(rxp[7:0]);
    assign par_bad1 = a_s_r.p != dcd_odd(rxp[15:8]);

    always_ff @(posedge mclk)
        if (!rst_b)
        begin
            rw_r <= '0;
            rcnt_r <= '0;
            hcnt_r <= '0;
            host_rd_valid <= 1'b0;
        end
        else if (ce)
        begin
            if (rd_data)
            begin
                rw_r[63:0] <= {rxp, rw_r[63:16]};
                rcnt_r <= rcnt_r + 2'h1;
                if (rcnt_r == RD_LAST)
                begin
                    rw_r[71:64] <= dcd_chk({rxp, rw_r[63:16]});
                    host_rd_valid <= 1'b1;
                end
            end
            else if (host_rd_valid && host_rd_ready)
            begin
                rw_r <= {12'h000, rw_r[71:12]};
                hcnt_r <= (hcnt_r == HOST_LAST) ? 3'h0 : hcnt_r + 3'h1;
                if (hcnt_r == HOST_LAST)
                    host_rd_valid <= 1'b0;
            end
        end

    assign host_rd_data = rw_r[11:0];

    // ID compare and ending status
    always_ff @(posedge mclk)
        if (!rst_b)
        begin
            id_hit0_r <= 1'b0;
            id_match_r <= 1'b0;
            stat_byte_r <= '0;
            stat_seen_r <= 1'b0;
        end
        else if (ce)
        begin
            if (rx_take && mode_r == MODE_ID && sec_r == 16'h0000)
                id_hit0_r <= rxp == id0_r;
            if (rx_take && mode_r == MODE_ID && sec_r == 16'h0001)
                id_match_r <= id_hit0_r && rxp == id1_r;
            if (rx_take && mode_r == MODE_STAT)
                stat_byte_r <= rxp[7:0];
            stat_seen_r <= (rx_take && mode_r == MODE_STAT) || (stat_seen_r && !stat_rd);
        end

    // status unit: a new event in the clearing cycle survives
    always_comb
    begin
        err_set = '0;
        err_set.sbe = ce && wst_r == W_CHECK && sgl;
        err_set.dbe = ce && wst_r == W_CHECK && dbl;
        err_set.par0 = rx_take && par_bad0;
        err_set.par1 = rx_take && par_bad1;
        err_set.ecc = rx_take && mode_r == MODE_READ && ecc_ph
            && (rxp != {ehi_r[sec_r[1:0]], elo_r[sec_r[1:0]]});
        err_set.id_miss = rx_take && mode_r == MODE_ID && sec_r == 16'h0001 && !(id_hit0_r && rxp == id1_r);
    end

    always_ff @(posedge mclk)
        if (!rst_b)
            stat_r <= '0;
        else if (ce)
            stat_r <= (stat_rd ? '0 : stat_r) | err_set;

    // transfer counter
    always_ff @(posedge mclk)
        if (!rst_b)
            xfer_r <= '0;
        else if (ce)
        begin
            if (reg_wr && reg_addr == REG_XFER)
                xfer_r <= reg_wdata[15:0];
            else if ((tx_data || rd_data) && xfer_r != '0)
                xfer_r <= xfer_r - 16'h0001;
        end

    // sequencer
    assign sq_w = seq_mem[seq_addr_r];
    assign cond = {1'b1, pin_s_r[1], pin_s_r[0], stat_seen_r, stat_r.ecc, id_match_r, sec_r == SEC_END, xfer_r == '0};

    always_ff @(posedge mclk)
        if (ce && wr_sdata)
            seq_mem[seq_ptr_r] <= reg_wdata;

    always_ff @(posedge mclk)
        if (!rst_b)
        begin
            seq_addr_r <= '0;
            select_out <= 1'b0;
            master_out <= 1'b0;
        end
        else if (ce && run_r)
        begin
            if (sq_w[SQ_CLR])
                seq_addr_r <= '0;
            else if (sq_w[SQ_BR] && cond[sq_w[SQ_COND +: 3]])
                seq_addr_r <= sq_w[SQ_TGT +: 10];
            else
                seq_addr_r <= seq_addr_r + 10'h001;
            if (sq_w[SQ_SEL_SET] || sq_w[SQ_SEL_CLR])
                select_out <= sq_w[SQ_SEL_SET];
            if (sq_w[SQ_MST_SET] || sq_w[SQ_MST_CLR])
                master_out <= sq_w[SQ_MST_SET];
        end

    // register file
    always_ff @(posedge mclk)
        if (!rst_b)
        begin
            mode_r <= MODE_IDLE;
            run_r <= 1'b0;
            bsr_en_r <= 1'b0;
            bsr_head_r <= '0;
            cmd_r <= '0;
            id1_r <= '0;
            id0_r <= '0;
            seq_ptr_r <= '0;
        end
        else if (ce)
        begin
            if (wr_ctrl)
            begin
                mode_r <= dcd_mode_type'(reg_wdata[2:0]);
                run_r <= reg_wdata[3];
                bsr_en_r <= reg_wdata[4];
                bsr_head_r <= reg_wdata[7:5];
            end
            else if (run_r && sq_w[SQ_HALT])
                run_r <= 1'b0;
            if (reg_wr && reg_addr == REG_CMD_I)
                cmd_r[0] <= reg_wdata[7:0];
            if (reg_wr && reg_addr == REG_CMD_J)
                cmd_r[1] <= reg_wdata[7:0];
            if (reg_wr && reg_addr == REG_CMD_K)
                cmd_r[2] <= reg_wdata[7:0];
            if (reg_wr && reg_addr == REG_ID1)
                id1_r <= reg_wdata[15:0];
            if (reg_wr && reg_addr == REG_ID0)
                id0_r <= reg_wdata[15:0];
            if (reg_wr && reg_addr == REG_SEQ_PTR)
                seq_ptr_r <= reg_wdata[9:0];
            else if (wr_sdata || (reg_rd && reg_addr == REG_SEQ_DATA))
                seq_ptr_r <= seq_ptr_r + 10'h001;
        end

    always_ff @(posedge mclk)
        if (!rst_b)
            reg_rdata <= '0;
        else if (ce)
        begin
            reg_rdata <= '0;
            if (reg_rd)
                case (reg_addr)
                    REG_CTRL: reg_rdata <= {24'h000000, bsr_head_r, bsr_en_r, run_r, mode_r};
                    REG_CMD_I: reg_rdata <= {24'h000000, cmd_r[0]};
                    REG_CMD_J: reg_rdata <= {24'h000000, cmd_r[1]};
                    REG_CMD_K: reg_rdata <= {24'h000000, cmd_r[2]};
                    REG_ID1: reg_rdata <= {16'h0000, id1_r};
                    REG_ID0: reg_rdata <= {16'h0000, id0_r};
                    REG_XFER: reg_rdata <= {16'h0000, xfer_r};
                    REG_DEFECT: reg_rdata <= {16'h0000, defect_r};
                    REG_STATUS: reg_rdata <= {14'h0000, id_match_r, stat_seen_r, stat_byte_r, 2'h0, stat_r};
                    REG_PARCEL: reg_rdata <= {16'h0000, parcel_r};
                    REG_SEQ_PTR: reg_rdata <= {22'h000000, seq_ptr_r};
                    REG_SEQ_DATA: reg_rdata <= seq_mem[seq_ptr_r];
                    REG_SEQ_ADDR: reg_rdata <= {22'h000000, seq_addr_r};
                    default: reg_rdata <= '0;
                endcase
        end

    default clocking dcd_cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    a_fwd_five_beats: assert property (wst_r == W_FWD && ce && wcnt_r == FWD_LAST |=> wst_r == W_CHECK)
        else $error("forward did not end after five beats");
    a_single_fixed: assert property (ce && wst_r == W_CHECK && sgl |=> stat_r.sbe && ^cw_r[71:0] == 1'b0)
        else $error("single error not corrected or not reported");
    a_double_kept: assert property (ce && wst_r == W_CHECK && dbl |=> stat_r.dbe && cw_r[63:0] == $past(cw_r[63:0]))
        else $error("double error altered data or not reported");
    a_bus_odd_par: assert property (!bus_b_oe_b |-> bus_b_out.p == ~^bus_b_out.d)
        else $error("bus B parity not odd");
    a_par0_latch: assert property (rx_take && par_bad0 |=> stat_r.par0)
        else $error("byte 0 parity error lost");
    a_xfer_dec: assert property (tx_data && xfer_r != '0 && !reg_wr |=> xfer_r == $past(xfer_r) - 16'h0001)
        else $error("transfer counter did not decrement");
    a_seq_clear: assert property (ce && run_r && sq_w[SQ_CLR] |=> seq_addr_r == '0)
        else $error("sequencer address not cleared");
    a_status_hold: assert property (stat_r.ecc && !stat_rd |=> stat_r.ecc)
        else $error("ecc error dropped before status read");
    a_cmd_drive: assert property (cmd_stb |=> !bus_a_oe_b && bus_a_out.d == $past(cmd_sel))
        else $error("command byte not driven on bus A");

    c_word_sent: cover property (tx_data && wcnt_r == SEND_LAST);
    c_read_word: cover property (host_rd_valid && host_rd_ready && hcnt_r == HOST_LAST);
    c_ecc_miss: cover property (err_set.ecc);
    c_id_match: cover property (rx_take && mode_r == MODE_ID && sec_r == 16'h0001 && id_hit0_r && rxp == id1_r);
endmodule : dcd_datapath

// [test/dcd_drive_model.sv]
// dcd_drive_model: drive side of the parallel link, answers sync and logs parcels.
// assumes the datapath launches or takes one parcel per sync_out pulse.
`timescale 1ns/1ps
module dcd_drive_model (
    // link
    input wire logic mclk,
    input wire dcd_pkg::dcd_byte_type bus_a_out,
    input wire dcd_pkg::dcd_byte_type bus_b_out,
    input wire logic sync_out,
    output dcd_pkg::dcd_byte_type bus_a_in,
    output dcd_pkg::dcd_byte_type bus_b_in,
    output logic sync_in,
    // bench control and log
    input wire logic rdy,
    input wire logic [7:0] rd_byte,
    output int parcels,
    output int bad_par,
    output logic [15:0] last
);
    import dcd_pkg::*;
    assign sync_in = rdy;
    // both buses carry the byte; an idle bus shows it inverted with bad parity so a stale capture cannot pass
    assign bus_b_in = rdy ? {rd_byte, ~^rd_byte} : {~rd_byte, ^rd_byte};
    assign bus_a_in = bus_b_in;
    initial
    begin
        parcels = 0;
        bad_par = 0;
        last = '0;
    end
    always @(posedge mclk)
        if (sync_out === 1'b1)
        begin
            parcels <= parcels + 1;
            last <= {bus_a_out.d, bus_b_out.d};
            if (bus_a_out.p !== ~^bus_a_out.d || bus_b_out.p !== ~^bus_b_out.d)
                bad_par <= bad_par + 1;
        end
endmodule : dcd_drive_model

// [test/tb_disk_channel_datapath.sv]
// tb_disk_channel_datapath: register, host word and drive link scenarios.
// assumes dcd_drive_model on the link; ce and host read ready held high.
`timescale 1ns/1ps
module tb_disk_channel_datapath;
    import dcd_pkg::*;
    logic mclk = 0, rst_b = 0, reg_wr = 0, reg_rd = 0, host_wr_valid = 0, rdy = 0;
    logic [7:0] reg_addr = '0, rd_byte = '0;
    logic [31:0] reg_wdata = '0, reg_rdata, v;
    logic [11:0] host_wr_data = '0, host_rd_data;
    logic host_wr_ready, host_rd_valid, bus_a_oe_b, bus_b_oe_b, sync_in, select_out, master_out, sync_out;
    dcd_byte_type bus_a_in, bus_b_in, bus_a_out, bus_b_out;
    logic [15:0] last;
    int parcels, bad_par, num_errors = 0, checks = 0;
    dcd_datapath uut (.mclk, .rst_b, .ce(1'b1), .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .host_wr_data, .host_wr_valid, .host_wr_ready, .host_rd_data, .host_rd_valid, .host_rd_ready(1'b1),
        .bus_a_in, .bus_b_in, .bus_a_out, .bus_b_out, .bus_a_oe_b, .bus_b_oe_b, .slave_in(1'b0), .sync_in,
        .select_out, .master_out, .sync_out);
    dcd_drive_model drv (.mclk, .bus_a_out, .bus_b_out, .sync_out, .bus_a_in, .bus_b_in, .sync_in, .rdy,
        .rd_byte, .parcels, .bad_par, .last);
    initial
    begin
        forever #25 mclk = ~mclk;
    end
    task automatic close_out();
        $display("checks=%0d num_errors=%0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : close_out
    task automatic chk(input logic ok, input string msg);
        checks++;
        if (ok !== 1'b1)
        begin
            num_errors++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask : wr
    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask : rd
    task automatic await(input int n);
        for (int i = 0; i < 600 && parcels < n; i++)
            @(posedge mclk);
        if (parcels < n)
        begin
            chk(1'b0, "link stalled");
            close_out();
        end
    endtask : await
    task automatic word_case(input logic [71:0] w, input logic [1:0] e);
        int n;
        n = parcels;
        for (int b = 0; b < 6; b++)
        begin
            host_wr_data <= w[12*b +: 12];
            host_wr_valid <= 1'b1;
            for (int i = 0; i < 100 && host_wr_ready !== 1'b1; i++)
                @(negedge mclk);
            if (host_wr_ready !== 1'b1)
            begin
                chk(1'b0, "host port stalled");
                close_out();
            end
            @(posedge mclk);
        end
        host_wr_valid <= 1'b0;
        await(n + 4);
        chk(last === 16'h0000 && bad_par == 0, "parcel data or parity");
        rd(REG_STATUS);
        chk(v[1:0] === e, "error class");
        rd(REG_STATUS);
        chk(v[1:0] === 2'b00, "sticky bits not cleared");
    endtask : word_case
    // four parcels of one repeated byte come back as six beats, low beat first
    task automatic read_case();
        int n;
        logic [11:0] x;
        n = 0;
        wr(REG_CTRL, 32'h2);
        rd_byte <= 8'h3C;
        rdy <= 1'b1;
        for (int i = 0; i < 200 && n < 6; i++)
        begin
            @(negedge mclk);
            if (host_rd_valid === 1'b1)
            begin
                x = n[0] ? 12'h3C3 : 12'hC3C;
                chk(host_rd_data[3:0] === x[3:0] && (n == 5 || host_rd_data === x), "read beat");
                n++;
            end
        end
        @(posedge mclk);
        rdy <= 1'b0;
        if (n < 6)
        begin
            chk(1'b0, "read word missing");
            close_out();
        end
        rd(REG_STATUS);
        chk(v[5:0] === 6'h00, "read flags");
    endtask : read_case
    initial
    begin
        repeat (10) @(posedge mclk);
        rst_b <= 1'b1;
        rd(REG_STATUS);
        chk(v[16:0] === 17'h0, "status after reset");
        rd(8'hFC);
        chk(v === 32'h0, "unmapped read");
        wr(REG_SEQ_PTR, 32'h0);
        wr(REG_SEQ_DATA, 32'h1234ABCD);
        wr(REG_SEQ_DATA, 32'hFEDC5678);
        wr(REG_SEQ_PTR, 32'h0);
        rd(REG_SEQ_DATA);
        chk(v === 32'h1234ABCD, "sequencer word 0");
        rd(REG_SEQ_DATA);
        chk(v === 32'hFEDC5678, "sequencer word 1");
        wr(REG_CTRL, 32'h1);
        wr(REG_XFER, 32'h6);
        rdy <= 1'b1;
        word_case({8'h00, 64'h0001_0000_0000_0000}, 2'b01);
        rd(REG_XFER);
        chk(v === 32'h2, "transfer count");
        rd(REG_PARCEL);
        chk(v === 32'h4, "parcel count");
        word_case({8'h01, 64'h0}, 2'b01);
        word_case({8'h03, 64'h0}, 2'b10);
        rdy <= 1'b0;
        read_case();
        wr(REG_CTRL, 32'h4);
        rd_byte <= 8'hA5;
        rdy <= 1'b1;
        await(parcels + 1);
        rdy <= 1'b0;
        rd(REG_STATUS);
        chk(v[16:8] === 9'h1A5, "status byte");
        close_out();
    end
endmodule : tb_disk_channel_datapath
